// ### pkg/trap_vec_regs.svh
// register offsets, field positions, reset values and trap numbers
`ifndef TRAP_VEC_REGS_SVH
`define TRAP_VEC_REGS_SVH
`define OFF_TRAP_FLAGS   8'h00
`define OFF_NODE_REQ     8'h04
`define OFF_NODE_EN      8'h08
`define OFF_NODE_PRIO_LO 8'h0C
`define OFF_NODE_PRIO_HI 8'h10
`define OFF_STATUS       8'h14
`define OFF_SW_TRAP      8'h18
`define OFF_IRQ_STAT     8'h1C
`define OFF_IRQ_MASK     8'h20
`define OFF_CPU_PRIO     8'h24
`define TF_NMI          7
`define TF_STK_OVER     6
`define TF_STK_UNDER    5
`define TF_UNDEF_OP     4
`define TF_PROT_FAULT   3
`define TF_ILL_OPERAND  2
`define TF_ILL_INSTR    1
`define TF_ILL_BUS      0
`define TN_RESET     7'h00
`define TN_NMI       7'h02
`define TN_STK_OVER  7'h04
`define TN_STK_UNDER 7'h06
`define TN_CLASS_B 7'h0A
`define TN_EXT0    7'h18
`define RST_ZERO   32'h00000000
`define RESP_OKAY  2'h0
`define RESP_SLVERR 2'h2
`endif

// ### pkg/trap_vec_pkg.sv
// types shared by the trap and interrupt vectoring block
package trap_vec_pkg;
  localparam int NODES = 8;
  typedef enum logic [1:0] {CLS_NONE, CLS_RESET, CLS_A, CLS_B}
    trap_class_type;
  typedef struct packed {
    logic       valid;
    logic [6:0] number;
    logic [8:0] vector;
    logic [3:0] prio;
  } branch_type;
  typedef struct packed {
    logic nmi;
    logic stk_over;
    logic stk_under;
    logic undef_op;
    logic prot_fault;
    logic ill_operand;
    logic ill_instr;
    logic ill_bus;
  } trap_cond_type;
endpackage

// ### src/trap_vec_unit.sv
// interrupt and hardware trap vectoring unit with axi4-lite registers
`timescale 1ns/1ps
`include "trap_vec_regs.svh"
module trap_vec_unit (
  input  wire logic                     i_core_clk,    // cpu clock
  input  wire logic                     i_nrst,        // async reset, low
  input  wire logic                     i_ce,          // clock enable
  input  wire logic                     i_sys_reset,   // sw reset/watchdog
  input  wire trap_vec_pkg::trap_cond_type i_trap,     // trap pulses
  input  wire logic [7:0]               i_node_evt,    // peripheral events
  input  wire logic                     i_sw_trap,     // trap instruction
  input  wire logic [6:0]               i_sw_trap_num, // its trap number
  input  wire logic                     i_branch_ack,  // core took branch
  input  wire logic                     i_service_done,// return from service
  output logic                          o_branch_req,  // branch request
  output logic [6:0]                    o_trap_num,    // trap number
  output logic [8:0]                    o_vector,      // vector address
  output logic [3:0]                    o_new_prio,    // priority of entry
  output logic                          o_trap_active, // in trap service
  output logic                          o_irq,         // status interrupt
  input  wire logic [7:0]               s_axi_awaddr,  // write address
  input  wire logic                     s_axi_awvalid, // aw valid
  output logic                          s_axi_awready, // aw ready
  input  wire logic [31:0]              s_axi_wdata,   // write data
  input  wire logic [3:0]               s_axi_wstrb,   // byte strobes
  input  wire logic                     s_axi_wvalid,  // w valid
  output logic                          s_axi_wready,  // w ready
  output logic [1:0]                    s_axi_bresp,   // write response
  output logic                          s_axi_bvalid,  // b valid
  input  wire logic                     s_axi_bready,  // b ready
  input  wire logic [7:0]               s_axi_araddr,  // read address
  input  wire logic                     s_axi_arvalid, // ar valid
  output logic                          s_axi_arready, // ar ready
  output logic [31:0]                   s_axi_rdata,   // read data
  output logic [1:0]                    s_axi_rresp,   // read response
  output logic                          s_axi_rvalid,  // r valid
  input  wire logic                     s_axi_rready   // r ready
);
  import trap_vec_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  trap_flag_register;
  logic [7:0]  node_request_flag;
  logic [7:0]  node_enable;
  logic [31:0] node_prio;
  logic [3:0]  cpu_prio;
  logic [3:0]  prio_stack;
  logic        trap_active;
  logic        reset_pending;
  logic        sw_trap_req;
  logic [6:0]  sw_trap_num_r;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic        w_held;

  // ----------------------------------------------------------------
  // trap arbitration
  // ----------------------------------------------------------------
  // class a and class b condition groups
  wire [7:0] trap_vec = i_trap;
  wire       cls_a_nmi = i_trap.nmi;
  wire       cls_a_ovf = i_trap.stk_over;
  wire       cls_a_unf = i_trap.stk_under;
  wire       cls_b_any = i_trap.undef_op | i_trap.prot_fault |
                         i_trap.ill_operand | i_trap.ill_instr |
                         i_trap.ill_bus;
  wire       cls_a_any = cls_a_nmi | cls_a_ovf | cls_a_unf;
  // class a may pre-empt a class b service, never another class a
  wire       trap_busy_a;
  logic      active_cls_a;
  assign trap_busy_a = trap_active & active_cls_a;
  wire       take_a = cls_a_any & ~trap_busy_a;
  wire       take_b = cls_b_any & ~trap_active;
  // fixed trap numbers, reset above class a above class b
  wire [6:0] a_num = cls_a_nmi ? `TN_NMI :
                     (cls_a_ovf ? `TN_STK_OVER : `TN_STK_UNDER);
  wire [6:0] hw_num = reset_pending ? `TN_RESET :
                      (take_a ? a_num : `TN_CLASS_B);
  wire       hw_req = reset_pending | take_a | take_b;

  // ----------------------------------------------------------------
  // interrupt node selection
  // ----------------------------------------------------------------
  // pick highest priority enabled node, lowest index on ties
  logic [2:0] best_idx;
  logic [3:0] best_prio;
  logic       best_ok;
  always_comb begin
    best_idx  = 3'h0;
    best_prio = 4'h0;
    best_ok   = 1'b0;
    for (int k = 0; k < NODES; k++) begin
      if (node_request_flag[k] & node_enable[k] &
          (!best_ok || node_prio[4*k +: 4] > best_prio)) begin
        best_ok   = 1'b1;
        best_idx  = 3'(k);
        best_prio = node_prio[4*k +: 4];
      end
    end
  end
  // only a higher level than the running one pre-empts
  wire int_ok = best_ok & (best_prio > cpu_prio) & ~trap_active;
  wire [6:0] int_num = `TN_EXT0 + {4'h0, best_idx};

  // ----------------------------------------------------------------
  // branch request launch
  // ----------------------------------------------------------------
  wire busy = o_branch_req & ~i_branch_ack;
  wire launch_hw = hw_req & ~busy;
  wire launch_sw = sw_trap_req & ~hw_req & ~busy;
  wire launch_int = int_ok & ~hw_req & ~sw_trap_req & ~busy;
  wire [6:0] next_num = launch_hw ? hw_num :
                        (launch_sw ? sw_trap_num_r : int_num);
  wire [3:0] next_prio = launch_hw ? 4'hF :
                         (launch_sw ? cpu_prio : best_prio);
  wire launch = launch_hw | launch_sw | launch_int;

  // branch output registers; vector is always number times four
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_branch_req <= 1'b1; // hardware reset enters at vector zero
      o_trap_num   <= `TN_RESET;
      o_vector     <= 9'h000;
      o_new_prio   <= 4'hF;
    end else if (i_ce) begin
      if (launch) begin
        o_branch_req <= 1'b1;
        o_trap_num   <= next_num;
        o_vector     <= {next_num, 2'b00};
        o_new_prio   <= next_prio;
      end else if (i_branch_ack) begin
        o_branch_req <= 1'b0;
      end
    end
  end

  // service and priority tracking
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      trap_active   <= 1'b1;
      active_cls_a  <= 1'b0;
      cpu_prio      <= 4'h0;
      prio_stack    <= 4'h0;
      reset_pending <= 1'b0;
    end else if (i_ce) begin
      reset_pending <= i_sys_reset | (reset_pending & ~launch_hw);
      if (launch_hw) begin
        trap_active  <= 1'b1;
        active_cls_a <= reset_pending | take_a;
        prio_stack   <= cpu_prio;
        cpu_prio     <= 4'hF;
      end else if (launch_int) begin
        prio_stack <= cpu_prio;
        cpu_prio   <= best_prio;
      end else if (i_service_done) begin
        trap_active  <= 1'b0;
        active_cls_a <= 1'b0;
        cpu_prio     <= prio_stack;
      end
    end
  end

  // ----------------------------------------------------------------
  // flags: hardware set wins over software clear
  // ----------------------------------------------------------------
  wire wr_go = aw_held & w_held & ~s_axi_bvalid;
  wire wr_tf  = wr_go & (aw_addr == `OFF_TRAP_FLAGS);
  wire wr_req = wr_go & (aw_addr == `OFF_NODE_REQ);
  wire wr_en  = wr_go & (aw_addr == `OFF_NODE_EN);
  wire wr_plo = wr_go & (aw_addr == `OFF_NODE_PRIO_LO);
  wire wr_phi = wr_go & (aw_addr == `OFF_NODE_PRIO_HI);
  wire wr_sw  = wr_go & (aw_addr == `OFF_SW_TRAP);
  wire wr_ist = wr_go & (aw_addr == `OFF_IRQ_STAT);
  wire wr_msk = wr_go & (aw_addr == `OFF_IRQ_MASK);
  wire wr_known = wr_tf | wr_req | wr_en | wr_plo | wr_phi | wr_sw |
                  wr_ist | wr_msk;
  wire [7:0] tf_kept = wr_tf ? w_data[7:0] : trap_flag_register;
  wire [7:0] req_base = wr_req ? w_data[7:0] : node_request_flag;
  wire [7:0] req_taken = launch_int ? (8'h01 << best_idx) : 8'h00;
  wire [1:0] irq_evt = {launch_int, launch_hw & ~reset_pending};

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      trap_flag_register <= 8'h00;
      node_request_flag  <= 8'h00;
      node_enable        <= 8'h00;
      node_prio          <= `RST_ZERO;
      irq_stat           <= 2'h0;
      irq_mask           <= 2'h0;
      o_irq              <= 1'b0;
      sw_trap_req        <= 1'b0;
      sw_trap_num_r      <= 7'h00;
    end else if (i_ce) begin
      trap_flag_register <= tf_kept | trap_vec;
      node_request_flag  <= (req_base & ~req_taken) | i_node_evt;
      if (wr_en) node_enable <= w_data[7:0];
      if (wr_plo) node_prio[15:0] <= w_data[15:0];
      if (wr_phi) node_prio[31:16] <= w_data[15:0];
      if (wr_msk) irq_mask <= w_data[1:0];
      irq_stat <= (irq_stat & ~(wr_ist ? w_data[1:0] : 2'h0)) | irq_evt;
      o_irq    <= |(irq_stat & irq_mask);
      if (wr_sw | i_sw_trap) begin
        sw_trap_req   <= 1'b1;
        sw_trap_num_r <= i_sw_trap ? i_sw_trap_num : w_data[6:0];
      end else if (launch_sw) begin
        sw_trap_req <= 1'b0;
      end
    end
  end
  assign o_trap_active = trap_active;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= `RST_ZERO;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (i_ce) begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `OFF_TRAP_FLAGS:   rd_mux = {24'h0, trap_flag_register};
      `OFF_NODE_REQ:     rd_mux = {24'h0, node_request_flag};
      `OFF_NODE_EN:      rd_mux = {24'h0, node_enable};
      `OFF_NODE_PRIO_LO: rd_mux = {16'h0, node_prio[15:0]};
      `OFF_NODE_PRIO_HI: rd_mux = {16'h0, node_prio[31:16]};
      `OFF_STATUS:       rd_mux = {19'h0, trap_active, cpu_prio,
                                   o_branch_req, o_trap_num};
      `OFF_SW_TRAP:      rd_mux = {24'h0, sw_trap_req, sw_trap_num_r};
      `OFF_IRQ_STAT:     rd_mux = {30'h0, irq_stat};
      `OFF_IRQ_MASK:     rd_mux = {30'h0, irq_mask};
      `OFF_CPU_PRIO:     rd_mux = {28'h0, cpu_prio};
      default: begin
        rd_mux = `RST_ZERO;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `RST_ZERO;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (i_ce) begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign s_axi_arready = ~s_axi_rvalid;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_trap_in;
    !trap_active && !busy && (i_trap.undef_op || i_trap.ill_bus);
  endsequence
  a_class_b_vector: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst) ((i_ce && !reset_pending && !cls_a_any) and
    s_trap_in) |=> o_branch_req && o_trap_num == 7'h0A)
    else $error("class b trap not vectored to 0x0A");
  a_nmi_vector: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst) i_ce && launch_hw && !reset_pending && cls_a_nmi
    |=> o_vector == 9'h008 && o_trap_num == 7'h02)
    else $error("nmi vector wrong");
  a_flag_set: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst) i_ce && i_trap.stk_over
    |=> trap_flag_register[`TF_STK_OVER])
    else $error("stack overflow flag not set");
  a_vector_times4: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst) o_branch_req |-> o_vector == {o_trap_num, 2'b00})
    else $error("vector not number times four");
  a_reset_first: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst) i_ce && launch_hw && reset_pending
    |=> o_trap_num == 7'h00 && o_vector == 9'h000)
    else $error("reset not served first");
  a_int_blocked: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst) i_ce && trap_active && !launch_hw && !launch_sw
    |=> $stable(o_trap_num) && $stable(o_new_prio))
    else $error("interrupt pre-empted trap service");
  a_prio_higher: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst) i_ce && launch_int
    |=> o_new_prio > $past(cpu_prio))
    else $error("interrupt not of higher priority");
  a_sw_keep_prio: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst) i_ce && launch_sw
    |=> o_new_prio == $past(cpu_prio) && o_trap_num == $past(sw_trap_num_r))
    else $error("software trap changed priority");
  a_ext0_number: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst) i_ce && launch_int && best_idx == 3'h0
    |=> o_vector == 9'h060)
    else $error("ext int 0 vector wrong");
  a_trap_nomask: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst) i_ce && cls_a_any && !trap_active && !busy
    |=> o_branch_req ##0 o_new_prio == 4'hF)
    else $error("trap was masked");
endmodule

// ### bench/core_model.sv
// core model: takes branch requests, alternating prompt and slow acks
`timescale 1ns/1ps
module core_model (
  input  wire logic       i_core_clk, // cpu clock
  input  wire logic       i_nrst,     // async reset, low
  input  wire logic       i_req,      // branch request
  input  wire logic [6:0] i_num,      // trap number
  input  wire logic [8:0] i_vec,      // vector address
  input  wire logic [3:0] i_prio,     // entry priority
  output logic            o_ack,      // ack pulse
  output logic [6:0]      o_num,      // taken number
  output logic [8:0]      o_vec,      // taken vector
  output logic [3:0]      o_prio,     // taken priority
  output logic [7:0]      o_cnt       // branches taken
);
  logic [3:0] waited; // cycles the request has stood
  wire  [3:0] delay = o_cnt[0] ? 4'h4 : 4'h0; // every other ack is slow

  // one ack per request, payload captured while it is held
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ack  <= 1'b0;
      waited <= 4'h0;
      o_num  <= 7'h00;
      o_vec  <= 9'h000;
      o_prio <= 4'h0;
      o_cnt  <= 8'h00;
    end else if (o_ack || !i_req) begin
      o_ack  <= 1'b0;
      waited <= 4'h0;
    end else if (waited == delay) begin
      o_ack  <= 1'b1;
      o_num  <= i_num;
      o_vec  <= i_vec;
      o_prio <= i_prio;
      o_cnt  <= o_cnt + 8'h01;
    end else begin
      waited <= waited + 4'h1;
    end
  end
endmodule

// ### bench/interrupt_trap_vectoring_test.sv
// self-checking bench for the trap and interrupt vectoring unit
`timescale 1ns/1ps
`include "trap_vec_regs.svh"
module interrupt_trap_vectoring_test;
  import trap_vec_pkg::*;
  localparam logic [6:0] TNUM [8] = '{7'h0A, 7'h0A, 7'h0A, 7'h0A, 7'h0A,
                                      7'h06, 7'h04, 7'h02};
  localparam logic [6:0] SWN [2] = '{7'h7F, 7'h30};
  logic          clk, nrst, ce, sys_rst, swt, sdone, req, ack, act, irq, m1;
  logic          awv, awr, wv, wrd, bv, arv, arr, rv;
  logic [1:0]    bresp, rresp, rsp;
  logic [3:0]    prio, t_prio;
  logic [6:0]    swn, num, t_num;
  logic [7:0]    evt, awa, ara, t_cnt, last_cnt;
  logic [8:0]    vec, t_vec;
  logic [31:0]   wd, rdat, d;
  trap_cond_type trap;
  int            n_errors, checks_done, k;

  // 100 mhz clock
  always #5 clk = ~clk;

  trap_vec_unit dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_sys_reset(sys_rst),
    .i_trap(trap), .i_node_evt(evt), .i_sw_trap(swt), .i_sw_trap_num(swn),
    .i_branch_ack(ack), .i_service_done(sdone), .o_branch_req(req),
    .o_trap_num(num), .o_vector(vec), .o_new_prio(prio),
    .o_trap_active(act), .o_irq(irq), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1));

  core_model core (
    .i_core_clk(clk), .i_nrst(nrst), .i_req(req), .i_num(num),
    .i_vec(vec), .i_prio(prio), .o_ack(ack), .o_num(t_num),
    .o_vec(t_vec), .o_prio(t_prio), .o_cnt(t_cnt));

  // compare and count
  task automatic chk(input string what, input logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    n_errors++;
    $display("[ERR] %s expected answer seen timeout", what);
    results();
  endtask

  // axi4-lite write; bready stays high, so the response is taken at once
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
    end while (!bv && n < 100);
    if (n >= 100) hang("write");
    rsp = bresp;
  endtask

  // axi4-lite read; rready stays high
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && n < 100);
    if (n >= 100) hang("read");
    d = rdat;
    rsp = rresp;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, logic [31:0] e);
    rd(a);
    chk(what, e, d);
  endtask

  task automatic ptrap(input logic [7:0] v);
    trap <= trap_cond_type'(v);
    @(posedge clk);
    trap <= '0;
  endtask

  task automatic pev(input logic [7:0] v);
    evt <= v;
    @(posedge clk);
    evt <= 8'h00;
  endtask

  task automatic svc;
    sdone <= 1'b1;
    @(posedge clk);
    sdone <= 1'b0;
    @(posedge clk);
  endtask

  // wait for the core to take a branch, then compare what it took
  task automatic br(input string what, input logic [6:0] n7, logic [8:0] v);
    int n;
    n = 0;
    while (t_cnt === last_cnt && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (n >= 60) hang(what);
    chk(what, 32'(n7), 32'(t_num));
    chk(what, 32'(v), 32'(t_vec));
    last_cnt = t_cnt;
  endtask

  task automatic nobr(input int n);
    repeat (n) @(posedge clk);
    chk("no branch", 32'(last_cnt), 32'(t_cnt));
  endtask

  task automatic reset_check;
    br("reset entry", `TN_RESET, 9'h000);
    rchk("flags", `OFF_TRAP_FLAGS, `RST_ZERO);
    rchk("node enable", `OFF_NODE_EN, `RST_ZERO);
    svc();
    rchk("cpu prio", `OFF_CPU_PRIO, `RST_ZERO);
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    {sys_rst, swt, sdone, awv, wv, arv} = 6'h00;
    trap = '0;
    {evt, awa, ara, swn} = 31'h0;
    wd = 32'h0;
    n_errors = 0;
    checks_done = 0;
    last_cnt = 8'h00;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    reset_check();
    // each condition alone
    for (k = 0; k < 8; k++) begin
      ptrap(8'h01 << k);
      br("hw trap", TNUM[k], {TNUM[k], 2'b00});
      rchk("trap flag", `OFF_TRAP_FLAGS, 32'h1 << k);
      wr(`OFF_TRAP_FLAGS, 32'h0);
      svc();
    end
    // clock enable low freezes the block, so the pulse is lost
    ce <= 1'b0;
    ptrap(8'h80);
    ce <= 1'b1;
    nobr(8);
    rchk("frozen flags", `OFF_TRAP_FLAGS, `RST_ZERO);
    // all conditions at once
    ptrap(8'hFF);
    br("first of all", `TN_NMI, 9'h008);
    nobr(8);
    rchk("all flags", `OFF_TRAP_FLAGS, 32'hFF);
    rd(`OFF_STATUS);
    chk("status", 32'h1002, d & 32'h10FF);
    wr(`OFF_TRAP_FLAGS, 32'h0);
    svc();
    // node request held off by a class b service
    wr(`OFF_NODE_EN, 32'hFF);
    wr(`OFF_NODE_PRIO_LO, 32'h0000C935);
    wr(`OFF_NODE_PRIO_HI, 32'h0000CCCC);
    ptrap(8'h10);
    br("class b", `TN_CLASS_B, 9'h028);
    pev(8'h01);
    nobr(8);
    svc();
    br("node 0", `TN_EXT0, 9'h060);
    chk("node 0 prio", 32'h5, 32'(t_prio));
    svc();
    for (k = 1; k < 8; k++) begin
      pev(8'h01 << k);
      br("node", `TN_EXT0 + 7'(k), 9'h060 + 9'(4 * k));
      svc();
    end
    wr(`OFF_NODE_REQ, 32'h08);
    br("soft request", 7'h1B, 9'h06C);
    svc();
    for (k = 0; k < 2; k++) begin
      swn <= SWN[k];
      swt <= 1'b1;
      @(posedge clk);
      swt <= 1'b0;
      br("sw trap", SWN[k], {SWN[k], 2'b00});
      chk("sw trap prio", 32'h0, 32'(t_prio));
      svc();
    end
    // status interrupt, mask, clear, unmapped and read-only places
    rchk("irq status", `OFF_IRQ_STAT, 32'h3);
    wr(`OFF_IRQ_MASK, 32'h3);
    repeat (2) @(posedge clk);
    m1 = irq;
    wr(`OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq mask", 32'h1, 32'(m1 ^ irq));
    wr(`OFF_IRQ_MASK, 32'h3);
    wr(`OFF_IRQ_STAT, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    rchk("irq stat cleared", `OFF_IRQ_STAT, `RST_ZERO);
    wr(8'h40, 32'h1);
    chk("unmapped wr", 32'(`RESP_SLVERR), 32'(rsp));
    rd(8'h40);
    chk("unmapped rd", 32'(`RESP_SLVERR), 32'(rsp));
    chk("unmapped data", `RST_ZERO, d);
    wr(`OFF_CPU_PRIO, 32'hF);
    chk("ro wr resp", 32'(`RESP_SLVERR), 32'(rsp));
    rchk("cpu prio ro", `OFF_CPU_PRIO, `RST_ZERO);
    // nested entries by priority, then a trap over them
    pev(8'h01);
    br("node 0 again", `TN_EXT0, 9'h060);
    pev(8'h02);
    nobr(8);
    pev(8'h04);
    br("node 2", 7'h1A, 9'h068);
    chk("node 2 prio", 32'h9, 32'(t_prio));
    ptrap(8'h80);
    br("nmi over node", `TN_NMI, 9'h008);
    ptrap(8'h28);
    nobr(8);
    wr(`OFF_TRAP_FLAGS, 32'h0);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    br("sys reset", `TN_RESET, 9'h000);
    rchk("flags sys reset", `OFF_TRAP_FLAGS, `RST_ZERO);
    // second hardware reset in mid-run
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    last_cnt = 8'h00;
    nrst <= 1'b1;
    reset_check();
    results();
  end
endmodule
